//--- src/eau_regs.vh
// Register offsets, command bit positions and cycle counts of the extended arithmetic unit
`ifndef EAU_REGS_VH
`define EAU_REGS_VH

// Command register address in the CPU data space
`define EAU_CMD_ADDR 20'h0_3F07
`define EAU_CMD_RESET 8'h00

// Command bit positions
`define EAU_BIT_MULU 0
`define EAU_BIT_MULS 1
`define EAU_BIT_DIVU 2
`define EAU_BIT_RSVD 3
`define EAU_BIT_BADD 4
`define EAU_BIT_BADDC 5
`define EAU_BIT_BSUB 6
`define EAU_BIT_BSUBC 7

// Execution lengths in CPU cycles
`define EAU_CYC_MUL 5'h04
`define EAU_CYC_DIV 5'h15
`define EAU_CYC_BCD 5'h04

// Divide steps end when the countdown reaches this value (16 steps)
`define EAU_DIV_LAST 5'h05

`endif

//--- src/eau_unit.v
// Extended arithmetic unit: multiply, divide and BCD add/subtract started by one command write
`timescale 1ns/1ps
`include "eau_regs.vh"

// Behaviour
// - Unsigned multiply puts the 32-bit product of the word registers high-in-high, in 4 cycles, clearing V and C.
// - Signed multiply puts the signed product in both word registers in 4 cycles, clears V and C, updates N and Z.
// - Unsigned divide of the word pair by address register zero leaves quotient low, remainder high, in 21 cycles.
// - BCD add sums the two byte registers into the first in 4 cycles, clearing V and N, setting C and Z.
// - BCD add with carry also adds the carry flag, with the same flags and timing as BCD add.
// - BCD subtract takes byte two from byte one into byte one in 4 cycles, clearing V and N, setting C and Z.
// - BCD subtract with borrow also takes the carry flag off, storing into the first byte register in 4 cycles.
// - Command bits are 7 sub-borrow, 6 sub, 5 add-carry, 4 add, 2 divide, 1 signed multiply, bit 3 reserved zero.
// - Writing ones to the write-only command register of an idle unit starts the operation of the lowest bit set; all bits reset to zero.
// - Bit 0 starts unsigned multiply and every command bit is cleared by hardware when its operation ends.
// - Divide sets overflow when the quotient does not fit 16 bits, leaving N and Z undefined and C zero.
module eau_unit #(
  parameter ADDR_W = 20
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // CPU data write port
  input wire cpuWrEn,
  input wire [ADDR_W-1:0] cpuAddr,
  input wire [7:0] cpuWrData,
  // Operand registers of the CPU core
  input wire [15:0] wordRegLoIn,
  input wire [15:0] wordRegHiIn,
  input wire [15:0] addressRegZeroIn,
  input wire [7:0] byteRegFirstIn,
  input wire [7:0] byteRegSecondIn,
  input wire carryFlagIn,
  // Hold-off to the CPU pipeline
  output wire cpuHold,
  // Result write-back
  output reg [15:0] wordRegLoOut,
  output reg [15:0] wordRegHiOut,
  output reg [7:0] byteRegFirstOut,
  output reg wordWrite,
  output reg byteWrite,
  // Status word flag write-back
  output reg overflowFlag,
  output reg negativeFlag,
  output reg carryFlag,
  output reg zeroFlag,
  output reg flagsWrite
);

  // Command register and sequencing
  reg [7:0] cmd_q;
  reg [7:0] cmd_d;
  reg [4:0] cnt_q;
  reg [4:0] cnt_d;
  // Operand snapshots taken when the command is written
  reg [15:0] opA_q;
  reg [15:0] opB_q;
  reg [15:0] div_q;
  reg cin_q;
  reg ovf_q;
  // Divider state: partial remainder and dividend shifting into quotient
  reg [15:0] rem_q;
  reg [15:0] quo_q;

  wire cmdWrite;
  wire [7:0] cmdValid;
  wire [31:0] prodU;
  wire [31:0] prodS;
  wire [16:0] divTrial;
  wire divFits;
  wire [4:0] bcdLo;
  wire [4:0] bcdHi;
  wire [7:0] bcdRes;
  wire decimal_difference;
  wire bcdUseCin;

  // Pick the single lowest command bit so a stray double write still runs one operation
  function [7:0] eau_one_hot;
    input [7:0] v;
    begin
      eau_one_hot = v & (~v + 8'h01);
    end
  endfunction

  // One BCD digit step: returns carry/borrow out and corrected digit
  function [4:0] eau_bcd_digit;
    input [3:0] a;
    input [3:0] b;
    input cin;
    input sub;
    reg [4:0] t;
    begin
      t = 5'h00;
      if (sub) begin
        t = {1'b0, a} - {1'b0, b} - {4'h0, cin};
        eau_bcd_digit = t[4] ? {1'b1, t[3:0] - 4'h6} : {1'b0, t[3:0]};
      end else begin
        t = {1'b0, a} + {1'b0, b} + {4'h0, cin};
        eau_bcd_digit = (t > 5'h09) ? {1'b1, t[3:0] + 4'h6} : {1'b0, t[3:0]};
      end
    end
  endfunction

  // Write decode; writes while an operation is running are ignored since cmd_q must be zero
  assign cmdWrite = cpuWrEn && (cpuAddr == `EAU_CMD_ADDR) && (cmd_q == 8'h00);
  // Reserved bit 3 never starts anything
  assign cmdValid = eau_one_hot(cpuWrData & ~(8'h01 << `EAU_BIT_RSVD));
  assign cpuHold = (cmd_q != 8'h00);

  // Products from the snapshots; a single wide multiplier is shared in area by the tool
  assign prodU = opA_q * opB_q;
  assign prodS = $signed(opA_q) * $signed(opB_q);

  // Restoring divide trial subtraction
  assign divTrial = {rem_q, quo_q[15]} - {1'b0, div_q};
  // Quotient fits 16 bits only if the high dividend is below the divisor
  assign divFits = (wordRegHiIn < addressRegZeroIn);

  // BCD digit chain; subtract uses the second byte as subtrahend
  assign decimal_difference = cmd_q[`EAU_BIT_BSUB] | cmd_q[`EAU_BIT_BSUBC];
  assign bcdUseCin = (cmd_q[`EAU_BIT_BADDC] | cmd_q[`EAU_BIT_BSUBC]) & cin_q;
  assign bcdLo = eau_bcd_digit(opA_q[3:0], opB_q[3:0], bcdUseCin, decimal_difference);
  assign bcdHi = eau_bcd_digit(opA_q[7:4], opB_q[7:4], bcdLo[4], decimal_difference);
  assign bcdRes = {bcdHi[3:0], bcdLo[3:0]};

  // Command register next value and countdown load
  always @* begin
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    if (cmdWrite) begin
      cmd_d = cmdValid;
      if (cmdValid[`EAU_BIT_DIVU]) begin
        cnt_d = `EAU_CYC_DIV - 5'h01;
      end else if (cmdValid[`EAU_BIT_MULU] | cmdValid[`EAU_BIT_MULS]) begin
        cnt_d = `EAU_CYC_MUL - 5'h01;
      end else begin
        cnt_d = `EAU_CYC_BCD - 5'h01;
      end
    end else if (cmd_q != 8'h00) begin
      if (cnt_q == 5'h00) begin
        cmd_d = `EAU_CMD_RESET;
      end else begin
        cnt_d = cnt_q - 5'h01;
      end
    end
  end

  // Sequencer, snapshot and divider registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= `EAU_CMD_RESET;
      cnt_q <= 5'h00;
      opA_q <= 16'h0000;
      opB_q <= 16'h0000;
      div_q <= 16'h0000;
      cin_q <= 1'b0;
      ovf_q <= 1'b0;
      rem_q <= 16'h0000;
      quo_q <= 16'h0000;
    end else begin
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      if (cmdWrite) begin
        // Byte operations use the byte registers, word operations the word registers
        opA_q <= (cmdValid[`EAU_BIT_MULU] | cmdValid[`EAU_BIT_MULS]) ? wordRegLoIn : {8'h00, byteRegFirstIn};
        opB_q <= (cmdValid[`EAU_BIT_MULU] | cmdValid[`EAU_BIT_MULS]) ? wordRegHiIn : {8'h00, byteRegSecondIn};
        div_q <= addressRegZeroIn;
        cin_q <= carryFlagIn;
        ovf_q <= ~divFits;
        rem_q <= wordRegHiIn;
        quo_q <= wordRegLoIn;
      end else if (cmd_q[`EAU_BIT_DIVU] && (cnt_q >= `EAU_DIV_LAST)) begin
        // One quotient bit per cycle, sixteen cycles in all
        if (!divTrial[16]) begin
          rem_q <= divTrial[15:0];
          quo_q <= {quo_q[14:0], 1'b1};
        end else begin
          rem_q <= {rem_q[14:0], quo_q[15]};
          quo_q <= {quo_q[14:0], 1'b0};
        end
      end
    end
  end

  // Result and flag write-back on the final cycle of the operation
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wordRegLoOut <= 16'h0000;
      wordRegHiOut <= 16'h0000;
      byteRegFirstOut <= 8'h00;
      wordWrite <= 1'b0;
      byteWrite <= 1'b0;
      overflowFlag <= 1'b0;
      negativeFlag <= 1'b0;
      carryFlag <= 1'b0;
      zeroFlag <= 1'b0;
      flagsWrite <= 1'b0;
    end else begin
      wordWrite <= 1'b0;
      byteWrite <= 1'b0;
      flagsWrite <= 1'b0;
      if ((cmd_q != 8'h00) && (cnt_q == 5'h00)) begin
        flagsWrite <= 1'b1;
        overflowFlag <= 1'b0;
        carryFlag <= 1'b0;
        if (cmd_q[`EAU_BIT_MULU]) begin
          wordWrite <= 1'b1;
          wordRegHiOut <= prodU[31:16];
          wordRegLoOut <= prodU[15:0];
          negativeFlag <= prodU[31];
          zeroFlag <= (prodU == 32'h0000_0000);
        end else if (cmd_q[`EAU_BIT_MULS]) begin
          wordWrite <= 1'b1;
          wordRegHiOut <= prodS[31:16];
          wordRegLoOut <= prodS[15:0];
          negativeFlag <= prodS[31];
          zeroFlag <= (prodS == 32'h0000_0000);
        end else if (cmd_q[`EAU_BIT_DIVU]) begin
          // On overflow the word results and N/Z are meaningless
          wordWrite <= 1'b1;
          wordRegLoOut <= quo_q;
          wordRegHiOut <= rem_q;
          overflowFlag <= ovf_q;
          negativeFlag <= quo_q[15];
          zeroFlag <= (quo_q == 16'h0000);
        end else begin
          // Non-BCD inputs give an unguaranteed result
          byteWrite <= 1'b1;
          byteRegFirstOut <= bcdRes;
          negativeFlag <= 1'b0;
          carryFlag <= bcdHi[4];
          zeroFlag <= (bcdRes == 8'h00);
        end
      end
    end
  end

endmodule

//--- verification/eau_assertions.sv
// Port timing checker of the arithmetic unit
`timescale 1ns/1ps
`include "eau_regs.vh"
module eau_assertions #(
  parameter ADDR_W = 20
) (
  // Clock, reset and command write
  input wire clk,
  input wire rst,
  input wire cpuWrEn,
  input wire [ADDR_W-1:0] cpuAddr,
  input wire [7:0] cpuWrData,
  // Unit outputs
  input wire cpuHold,
  input wire [7:0] byteRegFirstOut,
  input wire wordWrite,
  input wire byteWrite,
  input wire overflowFlag,
  input wire negativeFlag,
  input wire carryFlag,
  input wire zeroFlag,
  input wire flagsWrite
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Command seen by an idle unit; busy writes are dropped
  wire take = cpuWrEn && cpuAddr == `EAU_CMD_ADDR && !cpuHold;
  AST_MUL_LEN: assert property (take && cpuWrData inside {8'h01, 8'h02} |=>
    cpuHold [*4] ##1 (!cpuHold && wordWrite))
    else $error("multiply timing");
  AST_DIV_LEN: assert property (take && cpuWrData == 8'h04 |=> cpuHold [*8] ##14 (!cpuHold && wordWrite))
    else $error("divide timing");
  AST_BCD_LEN: assert property (take &&
    cpuWrData inside {8'h10, 8'h20, 8'h40, 8'h80} |=> cpuHold [*4] ##1 (byteWrite && !wordWrite))
    else $error("bcd timing");
  AST_BCD_FLAGS: assert property (byteWrite |-> !overflowFlag && !negativeFlag &&
    zeroFlag == (byteRegFirstOut == 8'h00))
    else $error("bcd flags");
  AST_WORD_CARRY: assert property (wordWrite |-> flagsWrite && !carryFlag)
    else $error("word carry");
  AST_NO_START: assert property (take && (cpuWrData & 8'hF7) == 8'h00 |=> !cpuHold)
    else $error("idle code started");
  AST_PULSE_ONE: assert property (flagsWrite |=> !flagsWrite)
    else $error("pulse too long");
  AST_HOLD_END: assert property ($rose(flagsWrite) |-> $past(cpuHold) && !cpuHold)
    else $error("hold release");
endmodule

//--- verification/eau_cpu_model.sv
// CPU core model writing single command bits
`timescale 1ns/1ps
`include "eau_regs.vh"
module eau_cpu_model (
  // Clock and unit status
  input wire clk,
  input wire cpuHold,
  // Data write port
  output reg cpuWrEn = 1'b0,
  output reg [19:0] cpuAddr = 20'h0_0000,
  output reg [7:0] cpuWrData = 8'h00
);
  // Stall while busy, one write, then leave the bus inverted, never a stale match
  task automatic write(input [7:0] cmd);
    begin
      @(negedge clk);
      while (cpuHold !== 1'b0) @(negedge clk);
      @(posedge clk);
      cpuWrEn <= 1'b1;
      cpuAddr <= `EAU_CMD_ADDR;
      cpuWrData <= cmd;
      @(posedge clk);
      cpuWrEn <= 1'b0;
      cpuAddr <= ~`EAU_CMD_ADDR;
      cpuWrData <= ~cmd;
    end
  endtask
endmodule

//--- verification/extended_arith_unit_tb.sv
// Self-checking bench of the arithmetic unit
`timescale 1ns/1ps
module extended_arith_unit_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] lo = 16'h0000, hi = 16'h0000, a0 = 16'h0000;
  reg [7:0] b0 = 8'h00, b1 = 8'h00;
  reg cf = 1'b0;
  wire cpuWrEn, cpuHold, wordWrite, byteWrite, overflowFlag, negativeFlag, carryFlag, zeroFlag, flagsWrite;
  wire [19:0] cpuAddr;
  wire [7:0] cpuWrData, byteRegFirstOut;
  wire [15:0] wordRegLoOut, wordRegHiOut;
  integer err_count = 0, comparisons = 0, i, k;
  // Free-running CPU clock
  always #4 clk = ~clk;
  eau_cpu_model u_eau_cpu_model (.clk, .cpuHold, .cpuWrEn, .cpuAddr, .cpuWrData);
  eau_unit u_eau_unit (.clk, .rst, .cpuWrEn, .cpuAddr, .cpuWrData, .wordRegLoIn(lo), .wordRegHiIn(hi),
    .addressRegZeroIn(a0), .byteRegFirstIn(b0), .byteRegSecondIn(b1), .carryFlagIn(cf), .cpuHold, .wordRegLoOut,
    .wordRegHiOut, .byteRegFirstOut, .wordWrite, .byteWrite, .overflowFlag, .negativeFlag, .carryFlag, .zeroFlag,
    .flagsWrite);
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task cmpData(input string name, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", name, e, g);
      end
    end
  endtask
  // Decimal model: carry flag above 99, borrow below 0
  function [8:0] bcd(input [7:0] a, input [7:0] b, input c, input s);
    integer x, y, r;
    begin
      x = a[7:4] * 10 + a[3:0];
      y = b[7:4] * 10 + b[3:0] + c;
      r = s ? x - y : x + y;
      bcd[8] = s ? r < 0 : r > 99;
      r = (r + 100) % 100;
      bcd[7:0] = (r / 10) * 16 + r % 10;
    end
  endfunction
  // Load operands, issue command bit n, check result, length and strobes
  task runOp(input integer n, input [15:0] l, input [15:0] h, input [15:0] z, input [7:0] x, input [7:0] y, input c);
    reg [31:0] w, q, r;
    reg [8:0] d;
    reg [3:0] f, m;
    integer t;
    begin
      @(posedge clk);
      {lo, hi, a0, b0, b1, cf} <= {l, h, z, x, y, c};
      w = l * h;
      if (n == 1) w = $signed(l) * $signed(h);
      f = {1'b0, w[31], 1'b0, w == 0};
      q = {h, l} / z;
      r = {h, l} % z;
      if (n == 2) w = {r[15:0], q[15:0]};
      if (n == 2) f = {h >= z, q[15], 1'b0, q[15:0] == 0};
      d = bcd(x, y, c & n[0], n[1]);
      if (n > 3) f = {3'b000, d[8], d[7:0] == 0};
      m = (n == 2 && f[3]) ? 4'hA : 4'hF;
      u_eau_cpu_model.write(8'h01 << n);
      {lo, hi, a0, b0, b1, cf} <= ~{l, h, z, x, y, c};
      t = 0;
      while (flagsWrite !== 1'b1 && t < 30) begin
        @(posedge clk);
        #1;
        t = t + 1;
      end
      cmpData("cycles", (n == 2) ? 21 : 4, t);
      cmpData("flags", f & m, {overflowFlag, negativeFlag, carryFlag, zeroFlag} & m);
      if (n > 3) cmpData("byte", d[7:0], byteRegFirstOut);
      else if (m[2]) cmpData("words", w, {wordRegHiOut, wordRegLoOut});
      cmpData("strobes", (n > 3) ? 3 : 5, {wordWrite, byteWrite, flagsWrite});
    end
  endtask
  // Reset, corner cases, then random traffic
  initial begin
    void'($urandom(58341));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    u_eau_cpu_model.write(8'h08);
    u_eau_cpu_model.write(8'h00);
    repeat (6) @(posedge clk);
    #1 cmpData("idle", 0, {cpuHold, flagsWrite});
    runOp(0, 16'hFFFF, 16'hFFFF, 0, 0, 0, 0);
    runOp(0, 16'h0000, 16'h0005, 0, 0, 0, 1);
    runOp(1, 16'h8000, 16'h8000, 0, 0, 0, 0);
    runOp(1, 16'hFFFF, 16'h0003, 0, 0, 0, 0);
    runOp(2, 16'h0007, 16'h1233, 16'h1234, 0, 0, 0);
    runOp(2, 16'h0007, 16'h1234, 16'h1234, 0, 0, 0);
    runOp(2, 16'h0001, 16'h0000, 16'h0000, 0, 0, 0);
    runOp(4, 0, 0, 0, 8'h99, 8'h99, 1);
    runOp(5, 0, 0, 0, 8'h99, 8'h00, 1);
    runOp(6, 0, 0, 0, 8'h00, 8'h01, 1);
    runOp(7, 0, 0, 0, 8'h00, 8'h00, 1);
    for (i = 0; i < 60; i = i + 1) begin
      k = $urandom % 7;
      runOp(k + (k > 2), 16'($urandom), 16'($urandom), 16'($urandom), {4'($urandom % 10), 4'($urandom % 10)},
        {4'($urandom % 10), 4'($urandom % 10)}, 1'($urandom));
    end
    conclude;
  end
  // Watchdog well past the expected run length
  initial begin
    #60000;
    err_count = err_count + 1;
    conclude;
  end
endmodule
bind eau_unit eau_assertions #(.ADDR_W(ADDR_W)) u_eau_assertions (.clk, .rst, .cpuWrEn, .cpuAddr, .cpuWrData, .cpuHold,
  .byteRegFirstOut, .wordWrite, .byteWrite, .overflowFlag, .negativeFlag, .carryFlag, .zeroFlag, .flagsWrite);
